// file: hw/pudc_pkg.sv
// package: register map, field positions and reset values of the up/down counter block
package pudc_pkg;
   localparam int unsigned CNT_W = 4;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_LOAD   = 8'h04;
   localparam logic [7:0] OFF_COUNT  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_MASK   = 8'h10;
   // control field positions
   localparam int unsigned CTRL_LOAD_EN = 0;
   localparam int unsigned CTRL_CLEAR   = 1;
   localparam int unsigned CTRL_UP      = 2;
   localparam int unsigned CTRL_CARRY_N = 3;
   localparam int unsigned CTRL_W       = 4;
   // status field positions
   localparam int unsigned ST_TERM = 0;
   localparam int unsigned ST_WRAP = 1;
   localparam int unsigned ST_W    = 2;
   // reset values: carry input high (inhibited), direction bit low (pin decides)
   localparam logic [3:0] CTRL_RST = 4'h8;
   localparam logic [3:0] LOAD_RST = 4'h0;
   localparam logic [3:0] CNT_MAX  = 4'hF;
   localparam logic [3:0] CNT_MIN  = 4'h0;
endpackage

// file: hw/pudc_toggle_stage.sv
// file holds one toggle stage with level load and clear overrides
`timescale 1ns/1ps
module pudc_toggle_stage
   import pudc_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic clear,
   input  wire logic load_enable,
   input  wire logic load_bit,
   input  wire logic toggle,
   output logic      state
);
   // clear beats load, load beats toggle, toggle inverts on the edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= 1'b0;
      end else if (clear) begin
         state <= 1'b0;
      end else if (load_enable) begin
         state <= load_bit;
      end else if (toggle) begin
         state <= ~state;
      end
   end
endmodule

// file: hw/pudc_counter.sv
// file holds the up/down counter top with its AHB-Lite register slave
//
// Operation
// - Each state bit is a toggle stage that loads while loading is enabled, else inverts on a clock edge when its toggle input is 1.
// - While load enable is high the count copies the load bits and ignores counting edges.
// - While clear is high the count is forced to zero and counting edges are ignored.
// - The carry input is active low and while high the count holds.
// - When enabled the count steps by one on each rising clock edge in the selected direction.
// - Direction high counts up and direction low counts down.
// - The count is shown as a 4-bit binary value with bit 0 least significant.
// - The carry output is synchronous and active low, for cascading and terminal count.
// - At 15 counting up or 0 counting down the carry output is low for one whole clock cycle.
// - After load enable falls, counting resumes from the loaded value.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module pudc_counter
   import pudc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        carry_in_n,
   input  wire logic        load_enable,
   input  wire logic        clear,
   input  wire logic        count_up,
   input  wire logic        load_bit_0,
   input  wire logic        load_bit_1,
   input  wire logic        load_bit_2,
   input  wire logic        load_bit_3,
   output logic             count_bit_0,
   output logic             count_bit_1,
   output logic             count_bit_2,
   output logic             count_bit_3,
   output logic             carry_out_n,
   output logic             irq
);
   logic [CTRL_W-1:0] ctrl;
   logic [CNT_W-1:0]  load_reg;
   logic [ST_W-1:0]   status;
   logic [ST_W-1:0]   mask;
   logic [CNT_W-1:0]  count;
   logic [CNT_W-1:0]  toggle;
   logic [CNT_W-1:0]  load_val;
   logic              eff_load;
   logic              eff_clear;
   logic              eff_up;
   logic              eff_carry_n;
   logic              terminal;
   logic              step;
   logic              dp_valid;
   logic              dp_write;
   logic [7:0]        dp_addr;
   logic [31:0]       next_hrdata;
   logic              rd_status;

   // pins and software controls merge; either may drive
   assign eff_load    = load_enable | ctrl[CTRL_LOAD_EN];
   assign eff_clear   = clear | ctrl[CTRL_CLEAR];
   assign eff_up      = count_up | ctrl[CTRL_UP];
   // both carry inputs are active low, so either one high inhibits counting
   assign eff_carry_n = carry_in_n | ctrl[CTRL_CARRY_N];
   assign load_val    = {load_bit_3, load_bit_2, load_bit_1, load_bit_0} | load_reg;

   // counting only when no override holds and carry input is low
   assign step = ~eff_clear & ~eff_load & ~eff_carry_n;

   // toggle terms: bit i flips when all lower bits are 1 (up) or 0 (down)
   genvar i;
   generate
      for (i = 0; i < CNT_W; i++) begin : g_stage
         if (i == 0) begin : g_lsb
            assign toggle[i] = step;
         end else begin : g_upper
            assign toggle[i] = step & (eff_up ? &count[i-1:0] : ~|count[i-1:0]);
         end
         pudc_toggle_stage u_stage (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .clear       (eff_clear),
            .load_enable (eff_load),
            .load_bit    (load_val[i]),
            .toggle      (toggle[i]),
            .state       (count[i])
         );
      end
   endgenerate

   // terminal count per direction, gated by carry input
   assign terminal = ~eff_carry_n & (eff_up ? (count == CNT_MAX) : (count == CNT_MIN));
   assign carry_out_n = ~terminal;

   assign count_bit_0 = count[0];
   assign count_bit_1 = count[1];
   assign count_bit_2 = count[2];
   assign count_bit_3 = count[3];

   // ahb address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 8'h00;
      end else if (hready) begin
         dp_valid <= hsel & htrans[1];
         dp_write <= hwrite;
         dp_addr  <= haddr[7:0];
      end
   end

   // control and load registers written in data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl     <= CTRL_RST;
         load_reg <= LOAD_RST;
         mask     <= '0;
      end else if (dp_valid && dp_write) begin
         unique case (dp_addr)
            OFF_CTRL: ctrl     <= hwdata[CTRL_W-1:0];
            OFF_LOAD: load_reg <= hwdata[CNT_W-1:0];
            OFF_MASK: mask     <= hwdata[ST_W-1:0];
            default:  ;
         endcase
      end
   end

   // read data mux in address phase, registered into data phase
   always_comb begin
      next_hrdata = 32'h0000_0000;
      unique case (haddr[7:0])
         OFF_CTRL:   next_hrdata[CTRL_W-1:0] = ctrl;
         OFF_LOAD:   next_hrdata[CNT_W-1:0]  = load_reg;
         OFF_COUNT:  next_hrdata = {26'h0, terminal, ~carry_out_n ^ terminal, count};
         OFF_STATUS: next_hrdata[ST_W-1:0]   = status;
         OFF_MASK:   next_hrdata[ST_W-1:0]   = mask;
         default:    next_hrdata = 32'h0000_0000;
      endcase
   end

   assign rd_status = hready & hsel & htrans[1] & ~hwrite & (haddr[7:0] == OFF_STATUS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= next_hrdata;
      end
   end

   // sticky events: terminal count reached and counter wrapped; set wins over read-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= '0;
      end else begin
         for (int k = 0; k < ST_W; k++) begin
            if (rd_status) begin
               status[k] <= 1'b0;
            end
         end
         if (terminal) begin
            status[ST_TERM] <= 1'b1;
         end
         if (terminal && step) begin
            status[ST_WRAP] <= 1'b1;
         end
      end
   end

   assign irq       = |(status & mask);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
endmodule

// file: dv/pudc_monitor.sv
// pin-level checker for the up/down counter
`timescale 1ns/1ps
module pudc_monitor
   import pudc_pkg::*;
(
   input wire logic hclk, hresetn, clear, load_enable, count_up, carry_in_n, carry_out_n,
   input wire logic load_bit_0, load_bit_1, load_bit_2, load_bit_3,
   input wire logic count_bit_0, count_bit_1, count_bit_2, count_bit_3
);
   // packed count, load value and free-run condition
   wire [3:0] c = {count_bit_3, count_bit_2, count_bit_1, count_bit_0};
   wire [3:0] d = {load_bit_3, load_bit_2, load_bit_1, load_bit_0};
   wire       g = !clear && !load_enable;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_CLR: assert property (clear |=> c == CNT_MIN) else $error("clear");
   AST_LOAD: assert property (load_enable && !clear |=> c == $past(d)) else $error("load");
   AST_HOLD: assert property (g && carry_in_n |=> $stable(c)) else $error("hold");
   AST_UP: assert property (g && count_up |=> c == $past(c) || c == $past(c) + 4'h1)
      else $error("up step");
   AST_DN: assert property (g && !count_up |=> c == $past(c) || c == $past(c) - 4'h1)
      else $error("down step");
   AST_CO_SRC: assert property (!carry_out_n |-> !carry_in_n && c == (count_up ? CNT_MAX : 0))
      else $error("carry cause");
   AST_WRAP: assert property (!carry_out_n && g |=> c == ($past(count_up) ? 0 : CNT_MAX))
      else $error("wrap");
   AST_ONE: assert property (!carry_out_n && g && count_up ##1 count_up |-> carry_out_n)
      else $error("carry too long");
endmodule
bind pudc_counter pudc_monitor pudc_monitor_inst (.*);

// file: dv/pudc_next_stage.sv
// next more significant stage of a cascade
`timescale 1ns/1ps
module pudc_next_stage
   import pudc_pkg::*;
(
   input  wire logic            hclk, hresetn, carry_in_n, count_up,
   output logic     [CNT_W-1:0] count
);
   // steps only while the lower stage shows terminal count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         count <= CNT_MIN;
      else if (!carry_in_n)
         count <= count_up ? count + 4'h1 : count - 4'h1;
   end
endmodule

// file: dv/presettable_updown_counter4_test.sv
// self-checking bench for the counter with a cascaded stage
`timescale 1ns/1ps
module presettable_updown_counter4_test
   import pudc_pkg::*;
;
   logic        hclk, hresetn, hwrite;
   logic [1:0]  htrans;
   logic [7:0]  pv;
   logic [31:0] haddr, hwdata, r;
   logic [3:0]  p;
   wire  [31:0] hrdata;
   wire  [3:0]  nxt;
   wire         hreadyout, hresp, irq, carry_out_n, count_bit_0, count_bit_1, count_bit_2;
   wire         count_bit_3, load_enable, clear, count_up, carry_in_n;
   wire         load_bit_0, load_bit_1, load_bit_2, load_bit_3;
   wire  [4:0]  st = {carry_out_n, count_bit_3, count_bit_2, count_bit_1, count_bit_0};
   int          bad_count = 0, samples_checked = 0;
   // control pins: load, clear, up, carry-in, load value
   assign {load_enable, clear, count_up, carry_in_n, load_bit_3, load_bit_2, load_bit_1,
      load_bit_0} = pv;
   pudc_counter pudc_counter_inst (.*, .hsel(1'h1), .hsize(3'h2), .hready(hreadyout));
   pudc_next_stage pudc_next_stage_inst (.hclk, .hresetn, .carry_in_n(carry_out_n),
      .count_up, .count(nxt));
   // clock and hang limit
   initial begin
      hclk = 1'h0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      repeat (500) @(posedge hclk);
      bad_count++;
      end_sim;
   end
   task chk(input string n, input logic [31:0] e, s);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task see(input logic [31:0] e);
      @(negedge hclk);
      chk("carry and count", e, 32'(st));
   endtask
   task pins(input logic [7:0] v);
      @(posedge hclk);
      pv <= v;
   endtask
   // one AHB-Lite word transfer, read data kept in r
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      {htrans, hwrite, haddr} <= {2'h2, w, 24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      {htrans, hwdata} <= {2'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      r = hrdata;
      @(negedge hclk);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task t_regs;
      ahb(1'h0, OFF_CTRL, 32'h0);
      chk("ctrl", 32'(CTRL_RST), r);
      ahb(1'h0, 8'h20, 32'h0);
      chk("hole", 32'h0, r);
      ahb(1'h1, OFF_LOAD, 32'h5);
      ahb(1'h0, OFF_LOAD, 32'h0);
      chk("load reg", 32'h5, r);
      ahb(1'h1, OFF_LOAD, 32'h0);
      chk("hresp", 32'h0, 32'(hresp));
      ahb(1'h1, OFF_MASK, 32'h3);
      ahb(1'h1, OFF_CTRL, 32'h0);
   endtask
   // load 14 and count up through 15
   task t_up;
      pins(8'hAE);
      pins(8'h20);
      p = nxt;
      see(32'h1E);
      see(32'h0F);
      see(32'h10);
      chk("next stage", 32'(p + 4'h1), 32'(nxt));
   endtask
   task t_down;
      pins(8'h81);
      pins(8'h00);
      see(32'h11);
      see(32'h00);
      see(32'h1F);
   endtask
   // clear beats load, then carry-in high holds
   task t_clr;
      pins(8'hF5);
      pins(8'h30);
      see(32'h10);
      repeat (3) @(negedge hclk);
      see(32'h10);
   endtask
   task t_irq;
      chk("irq", 32'h1, 32'(irq));
      ahb(1'h1, OFF_MASK, 32'h0);
      chk("irq masked", 32'h0, 32'(irq));
      ahb(1'h1, OFF_MASK, 32'h3);
      ahb(1'h0, OFF_STATUS, 32'h0);
      chk("status", 32'h3, r);
      chk("irq cleared", 32'h0, 32'(irq));
   endtask
   // reset, then each scenario
   initial begin
      {hresetn, htrans, hwrite, haddr, hwdata} = 68'h0;
      pv = 8'h30;
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      t_regs;
      t_up;
      t_down;
      t_clr;
      t_irq;
      end_sim;
   end
endmodule
